// ==== rtl/port_a_wake_carrier_io.sv ====
`timescale 1ns/10ps
// Contract
// - Each direction bit makes its pin an output when 1, input when 0.
// - Output pins drive the data latch; reading returns the latch.
// - An output pin always has its pull-down switched off.
// - Input pins read the pin level; pull-down only when its option asks.
// - In halt, a rising edge on a wake pin wakes and restarts at vector.
// - Wake enable per pin comes from fixed options, not from registers.
// - Dual-edge option lets falling edges wake from halt as well.
// - Carrier option, bit 3 output, data 1: pin outputs a 38 kHz carrier.
// - Carrier option, bit 3 output, data 0: pin drives low, no carrier.
// - During halt the bit 3 pad is forced low.
// - Without the carrier option bit 3 is an ordinary port pin outside halt.
// - Schmitt option enables the bit 0 Schmitt wake buffer after reset.
// - Amplifier option drops bit 0 pull-downs, enables amplifier after reset.
// - Halt stops the clock; pin wake detection works without it.
// - After a wake, wait 64 clock cycles before the core moves on.
module port_a_wake_carrier_io
  import port_a_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [PORT_W-1:0] pad_i,
  output logic [PORT_W-1:0] pad_o,
  output logic [PORT_W-1:0] pad_oe_o,
  output logic [PORT_W-1:0] pulldown_en_o,
  input wire logic [PORT_W-1:0] pulldown_option_i,
  input wire logic [PORT_W-1:0] wake_option_i,
  input wire logic dual_edge_wake_option_i,
  input wire logic ir_carrier_option_i,
  input wire logic schmitt_wake_option_i,
  input wire logic amplifier_wake_option_i,
  input wire logic speaker_wake_option_i,
  input wire logic halt_req_i,
  output logic clk_stop_o,
  output logic wake_async_o,
  output logic core_hold_o,
  output logic vector_load_o,
  output logic [PC_W-1:0] wake_vector_o,
  output logic resume_o,
  output logic schmitt_buffer_en_o,
  output logic amp_wake_en_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] data_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clear_q;
  logic [DATA_W-1:0] prdata_q;
  logic [PORT_W-1:0] pin_sync;
  logic [PORT_W-1:0] pin_prev_q;
  logic [PORT_W-1:0] snapshot_q;
  logic [PORT_W-1:0] wake_en;
  logic [PORT_W-1:0] run_edge;
  logic [PORT_W-1:0] halt_edge;
  logic [PORT_W-1:0] read_value;
  logic wake_sync;
  logic carrier;
  logic carrier_run;
  logic halted;
  logic setup_phase;
  logic access_write;
  logic addr_mapped;
  logic schmitt_en_q;
  logic amp_en_q;
  logic options_taken_q;
  logic [SETTLE_CNT_W-1:0] settle_q;
  halt_state_t state_q;
  halt_state_t state_d;

  // ---------------------------------------------------------------
  // Pin synchronisers and carrier divider
  // ---------------------------------------------------------------
  // Pads are asynchronous; reads and run-mode edges only see the second stage.
  pin_sync #(
    .WIDTH(PORT_W)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(pad_i),
    .sync_o(pin_sync)
  );

  // The clockless wake request is brought back into the clock domain for the sequencer.
  pin_sync #(
    .WIDTH(1)
  ) u_wake_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(wake_async_o),
    .sync_o(wake_sync)
  );

  // The divider runs only while the carrier is really wanted, which saves toggling.
  assign carrier_run = ir_carrier_option_i & dir_q[CARRIER_BIT] & data_q[CARRIER_BIT] & ~halted;

  carrier_gen u_carrier_gen (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .enable_i(carrier_run),
    .carrier_o(carrier)
  );

  // ---------------------------------------------------------------
  // Wake enables from fixed options
  // ---------------------------------------------------------------
  // Bit 0 wake is also masked under the speaker option, so a bad fuse set stays harmless.
  always_comb begin
    wake_en = wake_option_i;
    if (speaker_wake_option_i) begin
      wake_en[ANALOG_BIT] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Per-bit pad drive, pull-downs and edge terms
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_bit
      // Output enable follows the direction bit alone.
      assign pad_oe_o[gi] = dir_q[gi];
      if (gi == CARRIER_BIT) begin : g_carrier
        // Halt forces the emitter pad low before anything else is considered.
        assign pad_o[gi] = halted ? 1'b0 :
                           ir_carrier_option_i ? (data_q[gi] & carrier) :
                           data_q[gi];
      end else begin : g_plain
        assign pad_o[gi] = data_q[gi];
      end
      if (gi == ANALOG_BIT) begin : g_analog
        // The amplifier needs a clean bias, so the bit 0 pull-down goes away.
        assign pulldown_en_o[gi] = ~dir_q[gi] & pulldown_option_i[gi] & ~amp_en_q;
      end else begin : g_pull
        assign pulldown_en_o[gi] = ~dir_q[gi] & pulldown_option_i[gi];
      end
      // Output pins read the latch, input pins the synchronised pad.
      assign read_value[gi] = dir_q[gi] ? data_q[gi] : pin_sync[gi];
      // Running-mode edges come from synchronised samples.
      assign run_edge[gi] = wake_en[gi] & ((pin_sync[gi] & ~pin_prev_q[gi]) |
                            (dual_edge_wake_option_i & ~pin_sync[gi] & pin_prev_q[gi]));
      // Halt edges compare the raw pad with the level seen at halt entry, no clock needed.
      assign halt_edge[gi] = wake_en[gi] & ((pad_i[gi] & ~snapshot_q[gi]) |
                             (dual_edge_wake_option_i & ~pad_i[gi] & snapshot_q[gi]));
    end
  endgenerate

  // Raw wake request restarts the oscillator while the clock is still stopped.
  assign wake_async_o = halted & (|halt_edge);

  // ---------------------------------------------------------------
  // Halt and wake sequencer
  // ---------------------------------------------------------------
  assign halted = (state_q == ST_HALT);

  // Next state of the halt sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (halt_req_i) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake_sync) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_q == SETTLE_LAST) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Settle counter runs only in the settle state and restarts on each wake.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q <= '0;
    end else if (state_q == ST_SETTLE) begin
      settle_q <= settle_q + 7'h01;
    end else begin
      settle_q <= '0;
    end
  end

  // Pin level at halt entry is the reference for the clockless edge compare.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      snapshot_q <= '0;
    end else if (state_q == ST_RUN) begin
      snapshot_q <= pin_sync;
    end
  end

  // Previous synchronised sample for running-mode edges.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_sync;
    end
  end

  // The core holds while halted and during the settle wait.
  assign clk_stop_o = halted;
  assign core_hold_o = (state_q != ST_RUN);
  assign vector_load_o = halted & wake_sync;
  assign wake_vector_o = WAKE_VECTOR;
  assign resume_o = (state_q == ST_SETTLE) & (settle_q == SETTLE_LAST);

  // ---------------------------------------------------------------
  // Option capture after reset release
  // ---------------------------------------------------------------
  // Options are taken once at the first edge after release, not tracked afterwards.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      schmitt_en_q <= 1'b0;
      amp_en_q <= 1'b0;
      options_taken_q <= 1'b0;
    end else if (!options_taken_q) begin
      schmitt_en_q <= schmitt_wake_option_i;
      amp_en_q <= amplifier_wake_option_i;
      options_taken_q <= 1'b1;
    end
  end

  assign schmitt_buffer_en_o = schmitt_en_q;
  assign amp_wake_en_o = amp_en_q;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign setup_phase = psel_i & ~penable_i;
  assign access_write = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign addr_mapped = (paddr_i == DIR_ADDR) | (paddr_i == DATA_ADDR) |
                       (paddr_i == IRQ_STATUS_ADDR) | (paddr_i == IRQ_MASK_ADDR);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_mapped;
  assign prdata_o = prdata_q;

  // Read data is prepared in the setup cycle so it leaves a flip-flop.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= '0;
      irq_clear_q <= '0;
    end else if (setup_phase && !pwrite_i) begin
      prdata_q <= '0;
      irq_clear_q <= '0;
      case (paddr_i)
        DIR_ADDR: begin
          prdata_q[PORT_W-1:0] <= dir_q;
        end
        DATA_ADDR: begin
          prdata_q[PORT_W-1:0] <= read_value;
        end
        IRQ_STATUS_ADDR: begin
          prdata_q[IRQ_W-1:0] <= irq_status_q;
          irq_clear_q <= irq_status_q;
        end
        IRQ_MASK_ADDR: begin
          prdata_q[IRQ_W-1:0] <= irq_mask_q;
        end
        default: begin
          prdata_q <= '0;
        end
      endcase
    end else if (!psel_i) begin
      irq_clear_q <= '0;
    end
  end

  // Direction register.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dir_q <= DIR_RESET;
    end else if (access_write && paddr_i == DIR_ADDR) begin
      dir_q <= pwdata_i[PORT_W-1:0];
    end
  end

  // Data latch; writes land even on input pins and show once the pin turns output.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      data_q <= DATA_RESET;
    end else if (access_write && paddr_i == DATA_ADDR) begin
      data_q <= pwdata_i[PORT_W-1:0];
    end
  end

  // Interrupt mask.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_q <= IRQ_RESET;
    end else if (access_write && paddr_i == IRQ_MASK_ADDR) begin
      irq_mask_q <= pwdata_i[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_WAKE_BIT] = vector_load_o;
    irq_set[IRQ_EDGE_BIT] = (state_q == ST_RUN) & (|run_edge);
  end

  // Only bits that the read reported are cleared, and a new event wins over the clear.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_q <= IRQ_RESET;
    end else if (psel_i && penable_i && !pwrite_i && paddr_i == IRQ_STATUS_ADDR) begin
      irq_status_q <= (irq_status_q & ~irq_clear_q) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  assign irq_o = |(irq_status_q & irq_mask_q);

endmodule

// ==== common/port_a_pkg.sv ====
package port_a_pkg;

  // ---------------------------------------------------------------
  // Bus and port widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 4;
  localparam int IRQ_W = 2;
  localparam int PC_W = 13;

  // ---------------------------------------------------------------
  // Register map: printed indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] DIR_INDEX = 8'h02;
  localparam logic [ADDR_W-1:0] DATA_INDEX = 8'h03;
  localparam logic [ADDR_W-1:0] DIR_ADDR = {DIR_INDEX[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] DATA_ADDR = {DATA_INDEX[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h14;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [PORT_W-1:0] DIR_RESET = 4'h0;
  localparam logic [PORT_W-1:0] DATA_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_EDGE_BIT = 1;
  localparam int CARRIER_BIT = 3;
  localparam int ANALOG_BIT = 0;
  localparam logic [PC_W-1:0] WAKE_VECTOR = 13'h0004;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CARRIER_HZ = 38_000;
  localparam int CARRIER_HALF_CYCLES = CLK_HZ / (2 * CARRIER_HZ);
  localparam int CARRIER_CNT_W = 10;
  localparam logic [CARRIER_CNT_W-1:0] CARRIER_LAST = 10'(CARRIER_HALF_CYCLES - 1);
  localparam int SETTLE_CYCLES = 64;
  localparam int SETTLE_CNT_W = 7;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = 7'(SETTLE_CYCLES - 1);

  // ---------------------------------------------------------------
  // Halt sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_SETTLE = 3'b100
  } halt_state_t;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ==== rtl/carrier_gen.sv ====
`timescale 1ns/10ps
module carrier_gen
  import port_a_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic enable_i,
  output logic carrier_o
);

  // ---------------------------------------------------------------
  // Infrared carrier divider
  // ---------------------------------------------------------------
  logic [CARRIER_CNT_W-1:0] count_q;
  logic carrier_q;

  // The half period rounds down, so the carrier runs slightly fast.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= '0;
      carrier_q <= 1'b0;
    end else if (!enable_i) begin
      count_q <= '0;
      carrier_q <= 1'b0;
    end else if (count_q == CARRIER_LAST) begin
      count_q <= '0;
      carrier_q <= ~carrier_q;
    end else begin
      count_q <= count_q + 10'h001;
    end
  end

  assign carrier_o = carrier_q;

endmodule

// ==== test/port_a_checker.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Port behaviour checker
// ---------------------------------------------------------------
module port_a_checker
  import port_a_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [PORT_W-1:0] pad_i,
  input wire logic [PORT_W-1:0] pad_o,
  input wire logic [PORT_W-1:0] pad_oe_o,
  input wire logic [PORT_W-1:0] pulldown_en_o,
  input wire logic [PORT_W-1:0] pulldown_option_i,
  input wire logic [PORT_W-1:0] wake_option_i,
  input wire logic ir_carrier_option_i,
  input wire logic schmitt_wake_option_i,
  input wire logic amplifier_wake_option_i,
  input wire logic clk_stop_o,
  input wire logic wake_async_o,
  input wire logic core_hold_o,
  input wire logic vector_load_o,
  input wire logic [PC_W-1:0] wake_vector_o,
  input wire logic resume_o,
  input wire logic schmitt_buffer_en_o,
  input wire logic amp_wake_en_o
);
  localparam int HALF = CARRIER_HALF_CYCLES;
  logic live_q;
  logic [CARRIER_CNT_W:0] hi_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Options are only captured one edge after reset, so wait for that.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end

  // Length of the current high half of the carrier.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hi_q <= '0;
    end else if (pad_o[3] && pad_oe_o[3] && ir_carrier_option_i) begin
      hi_q <= hi_q + 1'b1;
    end else begin
      hi_q <= '0;
    end
  end

  sequence wake_s;
    wake_async_o ##[1:4] vector_load_o;
  endsequence
  sequence settle_s;
    ##64 resume_o ##1 !core_hold_o;
  endsequence

  a_dir_write: assert property (
    psel_i && penable_i && pwrite_i && pstrb_i[0] && paddr_i == DIR_ADDR |=> pad_oe_o == $past(pwdata_i[3:0]))
    else $error("direction write not seen on pad enables");
  a_pull_out: assert property ((pulldown_en_o & pad_oe_o) == 4'h0)
    else $error("pull-down on an output pin");
  a_pull_option: assert property (
    pulldown_en_o[3:1] == (~pad_oe_o[3:1] & pulldown_option_i[3:1])) else $error("pull-down does not follow option");
  a_amp_pull: assert property (amp_wake_en_o |-> !pulldown_en_o[0])
    else $error("bit 0 pull-down with amplifier wake");
  a_halt_low: assert property (clk_stop_o |-> !pad_o[CARRIER_BIT])
    else $error("bit 3 pad high in halt");
  a_carrier_half: assert property (hi_q <= HALF)
    else $error("carrier high half too long");
  a_wake_rise: assert property (
    clk_stop_o && $past(clk_stop_o) && wake_option_i[2] && $rose(pad_i[2]) |-> wake_s)
    else $error("rising edge did not wake");
  a_settle_len: assert property (
    vector_load_o |-> (wake_vector_o == WAKE_VECTOR) ##0 settle_s) else $error("wake vector or settle length wrong");
  a_resume_gap: assert property (resume_o |-> $past(vector_load_o, 64))
    else $error("resume without settle time");
  a_plain_hold: assert property (
    !ir_carrier_option_i && !clk_stop_o && !$past(clk_stop_o) && !($past(psel_i) && $past(penable_i) && $past(pwrite_i))
    |-> $stable(pad_o)) else $error("pad drive changed without a write");
  a_buf_copy: assert property (
    live_q |-> schmitt_buffer_en_o == schmitt_wake_option_i && amp_wake_en_o == amplifier_wake_option_i)
    else $error("wake buffer enables do not follow options");
endmodule

bind port_a_wake_carrier_io port_a_checker i_chk (
  .clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pad_i, .pad_o, .pad_oe_o,
  .pulldown_en_o, .pulldown_option_i, .wake_option_i, .ir_carrier_option_i, .schmitt_wake_option_i,
  .amplifier_wake_option_i, .clk_stop_o, .wake_async_o, .core_hold_o, .vector_load_o, .wake_vector_o, .resume_o,
  .schmitt_buffer_en_o, .amp_wake_en_o);

// ==== test/port_a_pins.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// External pins model
// ---------------------------------------------------------------
module port_a_pins
  import port_a_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [PORT_W-1:0] pad_o_i,
  input wire logic [PORT_W-1:0] pad_oe_i,
  input wire logic [PORT_W-1:0] pulldown_i,
  input wire logic [PORT_W-1:0] ext_val_i,
  input wire logic [PORT_W-1:0] ext_en_i,
  output logic [PORT_W-1:0] pin_o
);
  // Two-state, so a floating pin starts from a known level instead of an unknown that never resolves.
  bit [PORT_W-1:0] float_q;

  // A floating pin flips every cycle so no stale level can pass for a read.
  always_ff @(posedge clk_sys_i) begin
    float_q <= ~pin_o;
  end

  // The chip wins over the outside driver; a pull-down holds a free pin low.
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pad_oe_i[i]) begin
        pin_o[i] = pad_o_i[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else if (pulldown_i[i]) begin
        pin_o[i] = 1'b0;
      end else begin
        pin_o[i] = float_q[i];
      end
    end
  end
endmodule

// ==== test/port_a_wake_carrier_io_tb.sv ====
`timescale 1ns/10ps
module port_a_wake_carrier_io_tb;
  import port_a_pkg::*;
  logic clk_sys_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, halt_req_i, irq_o, err;
  logic dual_edge_wake_option_i, ir_carrier_option_i, schmitt_wake_option_i, amplifier_wake_option_i;
  logic speaker_wake_option_i, clk_stop_o, wake_async_o, core_hold_o, vector_load_o, resume_o;
  logic schmitt_buffer_en_o, amp_wake_en_o;
  logic [ADDR_W-1:0] paddr_i;
  logic [DATA_W-1:0] pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i;
  logic [PORT_W-1:0] pad_i, pad_o, pad_oe_o, pulldown_en_o, pulldown_option_i, wake_option_i, ext_val, ext_en;
  logic [PC_W-1:0] wake_vector_o;
  int err_total, total_checks, n;

  port_a_wake_carrier_io i_dut (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .pad_i, .pad_o, .pad_oe_o, .pulldown_en_o, .pulldown_option_i, .wake_option_i,
    .dual_edge_wake_option_i, .ir_carrier_option_i, .schmitt_wake_option_i, .amplifier_wake_option_i,
    .speaker_wake_option_i, .halt_req_i, .clk_stop_o, .wake_async_o, .core_hold_o, .vector_load_o, .wake_vector_o,
    .resume_o, .schmitt_buffer_en_o, .amp_wake_en_o, .irq_o);
  port_a_pins i_pins (.clk_sys_i, .pad_o_i(pad_o), .pad_oe_i(pad_oe_o), .pulldown_i(pulldown_en_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pad_i));

  // 50 MHz system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) @(posedge clk_sys_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Counts settled cycles until a watched output (0 pad 3, 1 vector load, 2 resume) reaches a level, at most lim.
  // A selector is used rather than a reference, since a bit of a port-driven vector cannot be passed by reference.
  task automatic wait_for(input int sel, input logic v, input int lim);
    logic s;
    n = 0;
    s = (sel == 0) ? pad_o[3] : (sel == 1) ? vector_load_o : resume_o;
    while (s !== v && n < lim) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      s = (sel == 0) ? pad_o[3] : (sel == 1) ? vector_load_o : resume_o;
    end
    if (s !== v) begin
      err_total++;
      $display("[FAIL] t=%0t wait timed out got=%h exp=%h", $time, s, v);
    end
  endtask

  task automatic halt_now;
    @(posedge clk_sys_i) halt_req_i <= 1'b1;
    @(posedge clk_sys_i) halt_req_i <= 1'b0;
    #1;
  endtask

  // Hang guard.
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    final_report();
  end

  initial begin
    err_total = 0;
    total_checks = 0;
    {rst_i, psel_i, penable_i, pwrite_i, halt_req_i, paddr_i, pwdata_i} = '0;
    rst_i = 1'b1;
    pstrb_i = 4'hF;
    pulldown_option_i = 4'hF;
    wake_option_i = 4'h5;
    {dual_edge_wake_option_i, amplifier_wake_option_i, speaker_wake_option_i} = 3'h0;
    {ir_carrier_option_i, schmitt_wake_option_i} = 2'h3;
    ext_val = 4'h0;
    ext_en = 4'hF;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(1'b0, DIR_ADDR, 32'h0); chk(rd, 32'h0);
    #1 chk(pulldown_en_o, 32'hF);
    chk({amp_wake_en_o, schmitt_buffer_en_o}, 32'h1);
    apb(1'b1, DIR_ADDR, 32'h6);
    apb(1'b1, DATA_ADDR, 32'hF);
    @(posedge clk_sys_i) ext_en <= 4'h9;
    #1 chk(pad_oe_o, 32'h6);
    chk(pulldown_en_o, 32'h9);
    chk(pad_o[2:1], 32'h3);
    apb(1'b0, DATA_ADDR, 32'h0); chk(rd, 32'h6);
    @(posedge clk_sys_i) ext_val <= 4'h9;
    repeat (3) @(posedge clk_sys_i);
    apb(1'b0, DATA_ADDR, 32'h0); chk(rd, 32'hF);
    apb(1'b1, 8'h20, 32'hF);
    apb(1'b0, 8'h20, 32'h0); chk({err, rd[3:0]}, 32'h10);
    apb(1'b0, DIR_ADDR, 32'h0); chk(rd, 32'h6);
    // Carrier: one high half must last the divider length.
    @(posedge clk_sys_i) ext_en <= 4'h1;
    apb(1'b1, DIR_ADDR, 32'hE);
    wait_for(0, 1'b1, 2000);
    wait_for(0, 1'b0, 2000); chk(n, CARRIER_HALF_CYCLES);
    apb(1'b1, DATA_ADDR, 32'h6);
    n = 0;
    repeat (700) begin
      @(posedge clk_sys_i);
      #1 n += pad_o[3];
    end
    chk(n, 32'h0);
    // Halt with the carrier running, then wake on a rising edge of pin 2.
    apb(1'b1, DIR_ADDR, 32'h8);
    apb(1'b1, DATA_ADDR, 32'hF);
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    @(posedge clk_sys_i) ext_en <= 4'h7;
    ext_val <= 4'h0;
    repeat (8) @(posedge clk_sys_i);
    halt_now();
    chk({clk_stop_o, pad_o[3]}, 32'h2);
    @(posedge clk_sys_i) ext_val <= 4'h2;
    repeat (10) @(posedge clk_sys_i);
    #1 chk({clk_stop_o, wake_async_o}, 32'h2);
    @(posedge clk_sys_i) ext_val <= 4'h6;
    wait_for(1, 1'b1, 20); chk(wake_vector_o, 32'h4);
    wait_for(2, 1'b1, 100); chk(n, 32'd64);
    chk(irq_o, 32'h0);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    #1 chk(irq_o, 32'h1);
    apb(1'b0, IRQ_STATUS_ADDR, 32'h0); chk(rd[0], 32'h1);
    #1 chk(irq_o, 32'h0);
    // Second configuration: dual edge, amplifier and speaker wake, no carrier.
    @(posedge clk_sys_i) rst_i <= 1'b1;
    {dual_edge_wake_option_i, amplifier_wake_option_i, speaker_wake_option_i} <= 3'h7;
    ir_carrier_option_i <= 1'b0;
    wake_option_i <= 4'h4;
    ext_val <= 4'h4;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 chk({amp_wake_en_o, schmitt_buffer_en_o}, 32'h3);
    chk(pulldown_en_o, 32'hE);
    apb(1'b1, DIR_ADDR, 32'h8);
    apb(1'b1, DATA_ADDR, 32'h8);
    repeat (700) @(posedge clk_sys_i);
    #1 chk(pad_o[3], 32'h1);
    halt_now();
    chk(pad_o[3], 32'h0);
    @(posedge clk_sys_i) ext_val <= 4'h0;
    wait_for(1, 1'b1, 20); chk(vector_load_o, 32'h1);
    wait_for(2, 1'b1, 100); chk(n, 32'd64);
    final_report();
  end
endmodule
